//--- hdl/monitor_config_status_regs.sv
// Purpose: Config and status bytes of a temperature/voltage monitor, with sequencer
// Assumes: Serial engine hands over decoded byte commands; converter gives compares
// Notes:   One conversion slot per enabled channel, ended by done or timeout
`include "monitor_map.svh"

// Notes on behaviour
// - Mask-all bit stops every alert
// - Standby bit halts conversion immediately
// - Standby clear means continuous conversions
// - Bit 5 masks remote 1 alerts
// - Bit 4 masks remote 2 alerts
// - Bits 3..0 mask voltage and supply alerts
// - Bits 7..5 disable temperature channels
// - Bits 4..1 disable voltage channels
// - Bit 0 reserved, zero, no effect
// - Status bit 7 shows conversion busy
// - Internal high/low flags latch
// - Remote 1 high/low flags latch
// - Remote 2 high/low flags latch
// - Temperature flags clear on reset or read
// - Status bit 2 shows diode 1 fault
// - Over-temperature bits follow limit live
// - Status 2 bit 4 shows diode 2 fault
// - Voltage window flags latch, clear on read
// - Status reads 80h busy, 00h idle
module monitor_config_status_regs (
  input  wire logic                 sys_clk,
  input  wire logic                 arst_n,
  input  wire monitor_pkg::reg_req_t req,
  output logic [7:0]                rdData,
  output logic                      rdValid,
  input  wire monitor_pkg::compare_t cmpResult,
  input  wire logic                 convDone,
  output logic                      convStart,
  output monitor_pkg::channel_t     convChannel,
  output logic                      convBusy,
  output logic                      alertOut,
  output logic                      overtempOutput
);

  // ----------------------------------------------------------------
  // Configuration bytes
  // ----------------------------------------------------------------
  logic [7:0] cfg1_q;
  logic [7:0] cfg2_q;
  logic       wrCfg1;
  logic       wrCfg2;

  // Byte commands only; no address pointer is kept
  assign wrCfg1 = req.wrStrobe && (req.cmd == `CMD_WR_CONFIG1);
  assign wrCfg2 = req.wrStrobe && (req.cmd == `CMD_WR_CONFIG2);

  // Standby and masks act from the edge after the write
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg1_q <= `CFG1_RESET;
    end else if (wrCfg1) begin
      cfg1_q <= req.wrData;
    end
  end

  // Reserved bit is never stored so it reads zero
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg2_q <= `CFG2_RESET;
    end else if (wrCfg2) begin
      cfg2_q <= {req.wrData[7:1], 1'b0};
    end
  end

  // ----------------------------------------------------------------
  // Channel enables
  // ----------------------------------------------------------------
  // A set disable bit takes the channel out of the round
  logic [6:0] chanOn;

  always_comb begin
    chanOn = 7'h00;
    chanOn[monitor_pkg::ChInternal] = !cfg2_q[`CFG2_DIS_INT];
    chanOn[monitor_pkg::ChRemote1]  = !cfg2_q[`CFG2_DIS_R1];
    chanOn[monitor_pkg::ChRemote2]  = !cfg2_q[`CFG2_DIS_R2];
    chanOn[monitor_pkg::ChVin3]     = !cfg2_q[`CFG2_DIS_V3];
    chanOn[monitor_pkg::ChVin2]     = !cfg2_q[`CFG2_DIS_V2];
    chanOn[monitor_pkg::ChVin1]     = !cfg2_q[`CFG2_DIS_V1];
    chanOn[monitor_pkg::ChSupply]   = !cfg2_q[`CFG2_DIS_VCC];
  end

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  // Idle only after reset or in standby
  typedef enum logic [1:0] {
    SeqIdle, SeqConvert, SeqNext
  } seq_state_t;

  seq_state_t            seq_q;
  monitor_pkg::channel_t chan_q;
  logic [7:0]            timer_q;
  logic                  standby;
  logic                  sampleValid;

  assign standby = cfg1_q[`CFG1_STANDBY];

  // Wraps from the supply channel back to internal
  function automatic monitor_pkg::channel_t nextChan(input monitor_pkg::channel_t c);
    monitor_pkg::channel_t n;
    n = (c == monitor_pkg::ChSupply) ? monitor_pkg::ChInternal
                                     : monitor_pkg::channel_t'(c + 3'd1);
    return n;
  endfunction : nextChan

  // Conversions begin on their own after reset; standby aborts at once
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      seq_q <= SeqIdle;
    end else if (standby) begin
      seq_q <= SeqIdle;
    end else begin
      case (seq_q)
        SeqIdle: begin
          seq_q <= SeqNext;
        end
        SeqNext: begin
          if (chanOn[chan_q]) begin
            seq_q <= SeqConvert;
          end
        end
        SeqConvert: begin
          if (convDone || timer_q == 8'h00) begin
            seq_q <= SeqNext;
          end
        end
        default: begin
          seq_q <= SeqIdle;
        end
      endcase
    end
  end

  // Disabled channels are stepped over without a conversion slot
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      chan_q <= monitor_pkg::ChInternal;
    end else if (!standby) begin
      if (seq_q == SeqNext && !chanOn[chan_q]) begin
        chan_q <= nextChan(chan_q);
      end else if (seq_q == SeqConvert && (convDone || timer_q == 8'h00)) begin
        chan_q <= nextChan(chan_q);
      end
    end
  end

  // Bounds a conversion so a silent converter cannot hang the sequence
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      timer_q <= 8'h00;
    end else if (seq_q == SeqNext) begin
      timer_q <= 8'(`CONV_CYCLES - 1);
    end else if (timer_q != 8'h00) begin
      timer_q <= timer_q - 8'h01;
    end
  end

  assign convBusy    = (seq_q == SeqConvert);
  // Launch lasts one cycle and is never raised in standby
  assign convStart   = (seq_q == SeqNext) && chanOn[chan_q] && !standby;
  assign convChannel = chan_q;
  // A done outside a live conversion is ignored
  assign sampleValid = convBusy && convDone && !standby && chanOn[chan_q];

  // ----------------------------------------------------------------
  // Read decode and read-to-clear
  // ----------------------------------------------------------------
  // Only an exact status command clears flags
  logic rdSt1;
  logic rdSt2;

  assign rdSt1 = req.rdStrobe && (req.cmd == `CMD_RD_STATUS1);
  assign rdSt2 = req.rdStrobe && (req.cmd == `CMD_RD_STATUS2);

  // ----------------------------------------------------------------
  // Latched alert flags
  // ----------------------------------------------------------------
  // Index: 0 int hi, 1 int lo, 2 r1 hi, 3 r1 lo, 4 r2 hi, 5 r2 lo,
  // 6 voltage_input_3, 7 voltage_input_2, 8 voltage_input_1, 9 supply
  logic [9:0] flagSet;
  logic [9:0] flagClr;
  logic [9:0] flags;

  // Compares set flags whatever the masks say
  always_comb begin
    flagSet    = 10'h000;
    flagSet[0] = sampleValid && chan_q == monitor_pkg::ChInternal && cmpResult.aboveHigh;
    flagSet[1] = sampleValid && chan_q == monitor_pkg::ChInternal && cmpResult.belowLow;
    flagSet[2] = sampleValid && chan_q == monitor_pkg::ChRemote1 && cmpResult.aboveHigh;
    flagSet[3] = sampleValid && chan_q == monitor_pkg::ChRemote1 && cmpResult.belowLow;
    flagSet[4] = sampleValid && chan_q == monitor_pkg::ChRemote2 && cmpResult.aboveHigh;
    flagSet[5] = sampleValid && chan_q == monitor_pkg::ChRemote2 && cmpResult.belowLow;
    flagSet[6] = sampleValid && chan_q == monitor_pkg::ChVin3
                 && (cmpResult.aboveHigh || cmpResult.belowLow);
    flagSet[7] = sampleValid && chan_q == monitor_pkg::ChVin2
                 && (cmpResult.aboveHigh || cmpResult.belowLow);
    flagSet[8] = sampleValid && chan_q == monitor_pkg::ChVin1
                 && (cmpResult.aboveHigh || cmpResult.belowLow);
    flagSet[9] = sampleValid && chan_q == monitor_pkg::ChSupply
                 && (cmpResult.aboveHigh || cmpResult.belowLow);
  end

  // Each status read clears only its own byte
  assign flagClr = {{4{rdSt2}}, {6{rdSt1}}};

  // One sticky cell per latched flag
  for (genvar i = 0; i < 10; i++) begin : gFlag
    sticky_flag uFlag (
      .sys_clk  (sys_clk),
      .arst_n   (arst_n),
      .setPulse (flagSet[i]),
      .clrPulse (flagClr[i]),
      .flag     (flags[i])
    );
  end

  // ----------------------------------------------------------------
  // Live flags: diode faults and over-temperature
  // ----------------------------------------------------------------
  logic diode1_q;
  logic diode2_q;
  logic [2:0] overTemp_q;

  // Held from the last sample of that channel; a disabled channel keeps its value
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      diode1_q <= 1'b0;
      diode2_q <= 1'b0;
    end else if (sampleValid) begin
      if (chan_q == monitor_pkg::ChRemote1) begin
        diode1_q <= cmpResult.diodeFault;
      end
      if (chan_q == monitor_pkg::ChRemote2) begin
        diode2_q <= cmpResult.diodeFault;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      overTemp_q <= 3'h0;
    end else if (sampleValid) begin
      case (chan_q)
        monitor_pkg::ChInternal: begin
          overTemp_q[2] <= cmpResult.overTemp;
        end
        monitor_pkg::ChRemote1: begin
          overTemp_q[1] <= cmpResult.overTemp;
        end
        monitor_pkg::ChRemote2: begin
          overTemp_q[0] <= cmpResult.overTemp;
        end
        default: begin
          overTemp_q <= overTemp_q;
        end
      endcase
    end
  end

  // Shutdown output ignores every mask bit
  assign overtempOutput = |overTemp_q;

  // ----------------------------------------------------------------
  // Status bytes
  // ----------------------------------------------------------------
  logic [7:0] status1;
  logic [7:0] status2;

  // With no trips this reads 80h mid-conversion and 00h between
  assign status1 = {convBusy,
                    flags[0],
                    flags[1],
                    flags[2],
                    flags[3],
                    diode1_q,
                    flags[4],
                    flags[5]};

  assign status2 = {overTemp_q,
                    diode2_q,
                    flags[6],
                    flags[7],
                    flags[8],
                    flags[9]};

  // ----------------------------------------------------------------
  // Alert output
  // ----------------------------------------------------------------
  logic alertR1;
  logic alertR2;
  logic alertInt;
  logic [3:0] alertVolt;

  assign alertInt  = flags[0] | flags[1];
  assign alertR1   = (flags[2] | flags[3] | diode1_q) & !cfg1_q[`CFG1_MASK_R1];
  assign alertR2   = (flags[4] | flags[5] | diode2_q) & !cfg1_q[`CFG1_MASK_R2];
  // Flag index runs opposite to the mask bit order
  assign alertVolt[3] = flags[6] & !cfg1_q[`CFG1_MASK_V3];
  assign alertVolt[2] = flags[7] & !cfg1_q[`CFG1_MASK_V2];
  assign alertVolt[1] = flags[8] & !cfg1_q[`CFG1_MASK_V1];
  assign alertVolt[0] = flags[9] & !cfg1_q[`CFG1_MASK_VCC];


  // Internal channel has no mask bit of its own, only the global one
  assign alertOut = !cfg1_q[`CFG1_MASK_ALL]
                    && (alertInt || alertR1 || alertR2 || |alertVolt);

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdData <= `STATUS_RESET;
    end else if (req.rdStrobe) begin
      case (req.cmd)
        `CMD_RD_STATUS1: rdData <= status1;
        `CMD_RD_CONFIG1: rdData <= cfg1_q;
        `CMD_RD_STATUS2: rdData <= status2;
        `CMD_RD_CONFIG2: rdData <= cfg2_q;
        // Unknown commands read zero, not the last byte
        default:         rdData <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdValid <= 1'b0;
    end else begin
      // One-cycle answer; back-to-back reads allowed
      rdValid <= req.rdStrobe;
    end
  end

endmodule : monitor_config_status_regs

//--- hdl/monitor_map.svh
// Purpose: Command codes, bit positions and reset values of the monitor config/status bank
// Assumes: Byte-wide registers reached by command byte from the serial engine
// Notes:   Definitions only
`ifndef MONITOR_MAP_SVH
`define MONITOR_MAP_SVH

// ----------------------------------------------------------------
// Command bytes
// ----------------------------------------------------------------
`define CMD_RD_STATUS1  8'h02
`define CMD_RD_CONFIG1  8'h03
`define CMD_WR_CONFIG1  8'h09
`define CMD_RD_STATUS2  8'h32
`define CMD_RD_CONFIG2  8'h33
`define CMD_WR_CONFIG2  8'h34

// ----------------------------------------------------------------
// Config byte 1 fields
// ----------------------------------------------------------------
`define CFG1_MASK_ALL   7
`define CFG1_STANDBY    6
`define CFG1_MASK_R1    5
`define CFG1_MASK_R2    4
`define CFG1_MASK_V3    3
`define CFG1_MASK_V2    2
`define CFG1_MASK_V1    1
`define CFG1_MASK_VCC   0

// ----------------------------------------------------------------
// Config byte 2 fields
// ----------------------------------------------------------------
`define CFG2_DIS_R1     7
`define CFG2_DIS_R2     6
`define CFG2_DIS_INT    5
`define CFG2_DIS_V3     4
`define CFG2_DIS_V2     3
`define CFG2_DIS_V1     2
`define CFG2_DIS_VCC    1
`define CFG2_RSVD       0

// ----------------------------------------------------------------
// Status byte fields
// ----------------------------------------------------------------
`define ST1_BUSY        7
`define ST1_INT_HI      6
`define ST1_INT_LO      5
`define ST1_R1_HI       4
`define ST1_R1_LO       3
`define ST1_DIODE1      2
`define ST1_R2_HI       1
`define ST1_R2_LO       0
`define ST2_INT_OT      7
`define ST2_R1_OT       6
`define ST2_R2_OT       5
`define ST2_DIODE2      4

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define CFG1_RESET      8'h00
`define CFG2_RESET      8'h00
`define STATUS_RESET    8'h00
`define CONV_TIME_NS    1000
`define CONV_CYCLES     (((`CONV_TIME_NS) + 7) / 8)

`endif

//--- hdl/monitor_pkg.sv
// Purpose: Shared types of the monitor config/status bank
// Assumes: Seven measurement channels in a fixed order
// Notes:   Constants live in monitor_map.svh
package monitor_pkg;

  // ----------------------------------------------------------------
  // Channels, in sequence order
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ChInternal, ChRemote1, ChRemote2, ChVin3, ChVin2, ChVin1, ChSupply
  } channel_t;

  // Register access from the serial engine
  typedef struct packed {
    logic       rdStrobe;
    logic       wrStrobe;
    logic [7:0] cmd;
    logic [7:0] wrData;
  } reg_req_t;

  // Compare results for the sample that just finished
  typedef struct packed {
    logic aboveHigh;
    logic belowLow;
    logic overTemp;
    logic diodeFault;
  } compare_t;

endpackage : monitor_pkg

//--- hdl/sticky_flag.sv
// Purpose: One hardware-set, read-cleared flag
// Assumes: Set and clear are single-cycle pulses
// Notes:   Set wins over a clear in the same cycle
module sticky_flag (
  input  wire logic sys_clk,
  input  wire logic arst_n,
  input  wire logic setPulse,
  input  wire logic clrPulse,
  output logic      flag
);

  // ----------------------------------------------------------------
  // Flag
  // ----------------------------------------------------------------
  // A trip arriving with the read clear is kept for the next read
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      flag <= 1'b0;
    end else if (setPulse) begin
      flag <= 1'b1;
    end else if (clrPulse) begin
      flag <= 1'b0;
    end
  end

endmodule : sticky_flag

//--- sim/monitor_config_status_regs_asserts.sv
// Purpose: Port checks of the monitor config/status bank
// Assumes: Bound to monitor_config_status_regs
// Notes:   A shadow of the mask-all bit is kept from the write strobes
module monitor_config_status_regs_asserts (
  input wire logic                  sys_clk,
  input wire logic                  arst_n,
  input wire monitor_pkg::reg_req_t req,
  input wire logic [7:0]            rdData,
  input wire logic                  rdValid,
  input wire monitor_pkg::compare_t cmpResult,
  input wire logic                  convDone,
  input wire logic                  convStart,
  input wire monitor_pkg::channel_t convChannel,
  input wire logic                  convBusy,
  input wire logic                  alertOut,
  input wire logic                  overtempOutput
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  logic wrCfg1;
  logic maskAllQ;
  assign wrCfg1 = req.wrStrobe && req.cmd == 8'h09;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      maskAllQ <= 1'b0;
    end else if (wrCfg1) begin
      maskAllQ <= req.wrData[7];
    end
  end
  // ---
  // Properties
  // ---
  sequence s_launch;
    convStart ##1 convBusy;
  endsequence
  sequence s_halted;
    ##2 !convBusy [*4];
  endsequence
  property p_launch;
    convStart |-> s_launch;
  endproperty
  property p_busy_end;
    convBusy && convDone |=> !convBusy;
  endproperty
  // Converter timeout is 125 cycles, so busy may never stand longer
  property p_busy_bound;
    $rose(convBusy) |-> ##[1:130] !convBusy;
  endproperty
  property p_standby;
    wrCfg1 && req.wrData[6] |-> s_halted;
  endproperty
  property p_mask_all;
    maskAllQ |-> !alertOut;
  endproperty
  property p_rd_valid;
    req.rdStrobe |=> rdValid;
  endproperty
  property p_valid_pulse;
    !req.rdStrobe |=> !rdValid && $stable(rdData);
  endproperty
  property p_busy_bit;
    req.rdStrobe && req.cmd == 8'h02 |=> rdData[7] == $past(convBusy);
  endproperty
  property p_rsvd;
    req.rdStrobe && req.cmd == 8'h33 |=> !rdData[0];
  endproperty
  a_launch: assert property (p_launch) else $error("no busy after launch");
  a_busy_end: assert property (p_busy_end) else $error("busy after done");
  a_busy_bound: assert property (p_busy_bound) else $error("busy too long");
  a_standby: assert property (p_standby) else $error("busy in standby");
  a_mask_all: assert property (p_mask_all) else $error("alert while masked");
  a_rd_valid: assert property (p_rd_valid) else $error("no read answer");
  a_valid_pulse: assert property (p_valid_pulse) else $error("stray read");
  a_busy_bit: assert property (p_busy_bit) else $error("busy bit wrong");
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
endmodule : monitor_config_status_regs_asserts

//--- sim/conv_model.sv
// Purpose: Converter stand-in answering each launch after dly cycles
// Assumes: dly is at least 1
// Notes:   Between answers the compare lines carry the inverse value
module conv_model (
  input wire logic                  sys_clk,
  input wire logic                  arst_n,
  input wire logic                  convStart,
  input wire monitor_pkg::channel_t convChannel,
  input wire logic [7:0]            dly,
  input wire monitor_pkg::compare_t cmpTab [0:6],
  output logic                      convDone,
  output monitor_pkg::compare_t     cmpResult
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]            cntQ;
  monitor_pkg::channel_t chQ;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cntQ     <= 8'h00;
      chQ      <= monitor_pkg::ChInternal;
      convDone <= 1'b0;
    end else begin
      convDone <= !convStart && cntQ == 8'h01;
      if (convStart) begin
        cntQ <= dly;
        chQ  <= convChannel;
      end else if (cntQ != 8'h00) begin
        cntQ <= cntQ - 8'h01;
      end
    end
  end
  // Inverse when idle so a sample off the done pulse shows up as a wrong flag
  assign cmpResult = convDone ? cmpTab[chQ] : ~cmpTab[chQ];
endmodule : conv_model

//--- sim/monitor_config_status_regs_test.sv
// Purpose: Self-checking bench of the monitor config/status bank
// Assumes: Inputs change 1 ns after the rising edge
// Notes:   Flag rows hold channel, compare, masks and expected bytes
module monitor_config_status_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic       wr;
    logic [7:0] cmd;
    logic [7:0] dat;
  } reg_row_t;
  typedef struct packed {
    logic [2:0] ch;
    logic [3:0] cmp;
    logic [7:0] pre;
    logic       alrt;
    logic [7:0] post;
    logic [7:0] s1;
    logic [7:0] s2;
  } flag_row_t;
  logic                  sys_clk;
  logic                  arst_n;
  monitor_pkg::reg_req_t req;
  logic [7:0]            rdData;
  logic                  rdValid;
  monitor_pkg::compare_t cmpResult;
  logic                  convDone;
  logic                  convStart;
  monitor_pkg::channel_t convChannel;
  logic                  convBusy;
  logic                  alertOut;
  logic                  overtempOutput;
  logic [7:0]            dly;
  monitor_pkg::compare_t cmpTab [0:6];
  logic [7:0]            rd;
  int                    seen;
  int                    errorCnt;
  int                    nCompared;
  reg_row_t regRows [11] = '{'{0, 8'h03, 8'h00}, '{0, 8'h33, 8'h00}, '{0, 8'h32, 8'h00},
    '{1, 8'h09, 8'ha5}, '{0, 8'h03, 8'ha5}, '{1, 8'h09, 8'h00}, '{1, 8'h34, 8'hff},
    '{0, 8'h33, 8'hfe}, '{1, 8'h34, 8'h00}, '{0, 8'h33, 8'h00}, '{0, 8'h77, 8'h00}};
  flag_row_t flagRows [15] = '{'{3, 4'h8, 8'hbf, 0, 8'h00, 8'h00, 8'h08},
    '{1, 4'h8, 8'h00, 1, 8'h20, 8'h10, 8'h00}, '{1, 4'h4, 8'h00, 1, 8'h20, 8'h08, 8'h00},
    '{1, 4'h1, 8'h00, 1, 8'h20, 8'h04, 8'h00}, '{2, 4'h8, 8'h00, 1, 8'h10, 8'h02, 8'h00},
    '{2, 4'h4, 8'h00, 1, 8'h10, 8'h01, 8'h00}, '{2, 4'h1, 8'h00, 1, 8'h10, 8'h00, 8'h10},
    '{4, 4'h4, 8'h00, 1, 8'h04, 8'h00, 8'h04}, '{5, 4'h8, 8'h00, 1, 8'h02, 8'h00, 8'h02},
    '{6, 4'h4, 8'h00, 1, 8'h01, 8'h00, 8'h01}, '{0, 4'h2, 8'h00, 0, 8'h00, 8'h00, 8'h80},
    '{1, 4'h2, 8'h00, 0, 8'h00, 8'h00, 8'h40}, '{2, 4'h2, 8'h00, 0, 8'h00, 8'h00, 8'h20},
    '{0, 4'h4, 8'h00, 1, 8'h80, 8'h20, 8'h00}, '{0, 4'h8, 8'h00, 1, 8'h80, 8'h40, 8'h00}};
  logic [7:0] disBit [7] = '{8'h20, 8'h80, 8'h40, 8'h10, 8'h08, 8'h04, 8'h02};

  monitor_config_status_regs u_dut (.sys_clk(sys_clk), .arst_n(arst_n), .req(req),
    .rdData(rdData), .rdValid(rdValid), .cmpResult(cmpResult), .convDone(convDone),
    .convStart(convStart), .convChannel(convChannel), .convBusy(convBusy),
    .alertOut(alertOut), .overtempOutput(overtempOutput));
  conv_model u_conv (.sys_clk(sys_clk), .arst_n(arst_n), .convStart(convStart),
    .convChannel(convChannel), .dly(dly), .cmpTab(cmpTab), .convDone(convDone),
    .cmpResult(cmpResult));

  // ---
  // Tasks
  // ---
  task automatic tick;
    @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
    nCompared++;
    if (got !== exp) begin
      errorCnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic summarize;
    $display("compared %0d mismatches %0d", nCompared, errorCnt);
    if (errorCnt == 0 && nCompared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize
  // Strobe drops with a spare edge after, so back-to-back calls never touch it twice
  task automatic wrReg(input logic [7:0] c, input logic [7:0] d);
    req.wrStrobe = 1'b1;
    req.cmd      = c;
    req.wrData   = d;
    tick();
    req.wrStrobe = 1'b0;
    tick();
  endtask : wrReg
  task automatic rdReg(input logic [7:0] c, output logic [7:0] d);
    req.rdStrobe = 1'b1;
    req.cmd      = c;
    tick();
    req.rdStrobe = 1'b0;
    check("rdValid", {7'h00, rdValid}, 8'h01);
    d = rdData;
    tick();
  endtask : rdReg
  // Kind 0 waits for busy, 1 for a launch, 2 for the done of channel ch
  task automatic waitFor(input int kind, input int ch);
    for (int i = 0; i < 2000; i++) begin
      tick();
      if (kind == 0 ? convBusy === 1'b1 : kind == 1 ? convStart === 1'b1
          : convDone === 1'b1 && int'(convChannel) == ch) return;
    end
    errorCnt++;
    summarize();
  endtask : waitFor
  // Two supply samples make a full round with quiet compares, then latches are read off
  task automatic flush;
    waitFor(2, 6);
    waitFor(2, 6);
    rdReg(8'h02, rd);
    rdReg(8'h32, rd);
  endtask : flush

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    arst_n    = 1'b0;
    req       = '0;
    dly       = 8'h03;
    cmpTab    = '{default: '0};
    errorCnt  = 0;
    nCompared = 0;
    repeat (8) @(posedge sys_clk);
    #1 arst_n = 1'b1;
    foreach (regRows[i]) begin
      if (regRows[i].wr) begin
        wrReg(regRows[i].cmd, regRows[i].dat);
      end else begin
        rdReg(regRows[i].cmd, rd);
        check("register", rd, regRows[i].dat);
      end
    end
    $display("register rows done");
    waitFor(0, 0);
    rdReg(8'h02, rd);
    check("status busy", rd, 8'h80);
    foreach (flagRows[i]) begin
      flush();
      wrReg(8'h09, flagRows[i].pre);
      cmpTab[flagRows[i].ch] = flagRows[i].cmp;
      waitFor(2, flagRows[i].ch);
      tick();
      cmpTab[flagRows[i].ch] = '0;
      check("alert", {7'h00, alertOut}, {7'h00, flagRows[i].alrt});
      check("overtemp", {7'h00, overtempOutput}, {7'h00, |flagRows[i].s2[7:5]});
      if (flagRows[i].post != 8'h00) begin
        wrReg(8'h09, flagRows[i].post);
        check("masked alert", {7'h00, alertOut}, 8'h00);
      end
      wrReg(8'h09, 8'h00);
      rdReg(8'h02, rd);
      check("status1", rd & 8'h7f, flagRows[i].s1);
      rdReg(8'h32, rd);
      check("status2", rd, flagRows[i].s2);
    end
    rdReg(8'h02, rd);
    check("status1 reread", rd & 8'h7f, 8'h00);
    $display("flag rows done");
    dly = 8'h09;
    for (int c = 0; c < 7; c++) begin
      wrReg(8'h34, disBit[c]);
      repeat (40) tick();
      rdReg(8'h02, rd);
      rdReg(8'h32, rd);
      cmpTab[c] = 4'ha;
      seen = 0;
      repeat (300) begin
        tick();
        if (convStart && int'(convChannel) == c) seen++;
      end
      cmpTab[c] = '0;
      check("disabled launches", seen[7:0], 8'h00);
      rdReg(8'h02, rd);
      check("disabled status1", rd & 8'h7f, 8'h00);
      rdReg(8'h32, rd);
      check("disabled status2", rd, 8'h00);
    end
    wrReg(8'h34, 8'h00);
    $display("disable test done");
    waitFor(1, 0);
    wrReg(8'h09, 8'h40);
    check("standby busy", {7'h00, convBusy}, 8'h00);
    seen = 0;
    repeat (100) begin
      tick();
      if (convStart) seen++;
    end
    check("standby launches", seen[7:0], 8'h00);
    rdReg(8'h02, rd);
    check("status idle", rd, 8'h00);
    wrReg(8'h09, 8'h00);
    check("run launch", {7'h00, convStart}, 8'h01);
    $display("standby test done");
    wrReg(8'h09, 8'h25);
    cmpTab[0] = 4'h8;
    waitFor(2, 0);
    tick();
    cmpTab[0] = '0;
    check("alert before reset", {7'h00, alertOut}, 8'h01);
    waitFor(0, 0);
    arst_n = 1'b0;
    #1;
    check("reset busy", {7'h00, convBusy}, 8'h00);
    check("reset alert", {7'h00, alertOut}, 8'h00);
    tick();
    arst_n = 1'b1;
    rdReg(8'h03, rd);
    check("config1 after reset", rd, 8'h00);
    $display("reset test done");
    summarize();
  end
endmodule : monitor_config_status_regs_test

bind monitor_config_status_regs monitor_config_status_regs_asserts u_chk (
  .sys_clk(sys_clk), .arst_n(arst_n), .req(req), .rdData(rdData), .rdValid(rdValid),
  .cmpResult(cmpResult), .convDone(convDone), .convStart(convStart),
  .convChannel(convChannel), .convBusy(convBusy), .alertOut(alertOut),
  .overtempOutput(overtempOutput));
